/* File: rtl/qdsn_pkg.sv */
/*
 Package for the quadrature decoder snapshot and event block.
 Holds register offsets, widths and reset values shared by the design.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package qdsn_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_TASK_BOTH = 12'h008;
   localparam logic [11:0] OFF_TASK_MOTION = 12'h00c;
   localparam logic [11:0] OFF_TASK_DOUBLE = 12'h010;
   localparam logic [11:0] OFF_EVT_SAMPLE = 12'h100;
   localparam logic [11:0] OFF_EVT_REPORT = 12'h104;
   localparam logic [11:0] OFF_REPORT_INTERVAL = 12'h510;
   localparam logic [11:0] OFF_MOTION_TOTAL = 12'h514;
   localparam logic [11:0] OFF_MOTION_SNAP = 12'h518;
   localparam logic [11:0] OFF_DOUBLE_TOTAL = 12'h544;
   localparam logic [11:0] OFF_DOUBLE_SNAP = 12'h548;
   localparam int ADDR_W = 12;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [15:0] INTERVAL_RESET = 16'h000a;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Sample stream from the decoder front end
   typedef struct packed {
      logic valid;       // One-cycle pulse per new sample
      logic [31:0] motion;   // Signed displacement of this sample
      logic [3:0] doubles;   // Double transitions seen in this sample
   } qdsn_sample_t;
endpackage

/* File: rtl/qdsn_top.sv */
/*
 Snapshot-and-clear tasks plus new-sample and report-nonzero events of a
 quadrature decoder, reached over AXI4-Lite.
 Assumes the front end delivers one-cycle sample pulses on aclk.
*/
// Functional notes
// - Snapshot-both copies motion and double totals, then clears both, atomically.
// - Snapshot-motion copies motion total then clears it, no transition lost between.
// - Snapshot-double copies double total then clears it, atomically.
// - New-sample event is raised on every new motion sample.
// - Report event set after interval samples with nonzero motion total, or by a software write of 1.
// - Report interval holds sample count before report and double events eligible.
`timescale 1ns/1ps
`default_nettype none
module qdsn_top
   import qdsn_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire qdsn_sample_t sample_in,
   output logic double_seen_event,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] motion_total;
      logic [31:0] double_total;
      logic [31:0] motion_snap;
      logic [31:0] double_snap;
      logic [15:0] interval;
      logic [15:0] count;
      logic new_sample_event;
      logic report_nonzero_event;
      logic double_seen_event;
   } qdsn_state_t;

   qdsn_state_t st_ff;
   qdsn_state_t nxt_st;
   logic wr_fire;
   logic rd_fire;
   logic task_both;
   logic task_motion;
   logic task_double;
   logic interval_done;
   logic [31:0] motion_sum;
   logic [31:0] double_sum;
   logic report_sw_set;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Handshake outputs combinational, one write and one read at a time, side by side
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;
   assign double_seen_event = st_ff.double_seen_event;

   assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   // Tasks trigger only on a write with bit 0 set
   assign task_both = wr_fire && st_ff.w_data[0] && hit(st_ff.aw_addr, OFF_TASK_BOTH);
   assign task_motion = wr_fire && st_ff.w_data[0] && hit(st_ff.aw_addr, OFF_TASK_MOTION);
   assign task_double = wr_fire && st_ff.w_data[0] && hit(st_ff.aw_addr, OFF_TASK_DOUBLE);
   // Software may set the report event by writing 1, so its check must allow it
   assign report_sw_set = wr_fire && st_ff.w_data[0] && hit(st_ff.aw_addr, OFF_EVT_REPORT);

   // Totals including this cycle's sample, so a copy never misses one
   assign motion_sum = st_ff.motion_total + (sample_in.valid ? sample_in.motion : REG_RESET);
   assign double_sum = st_ff.double_total + (sample_in.valid ? {28'h000_0000, sample_in.doubles} : REG_RESET);
   assign interval_done = sample_in.valid && (st_ff.count + COUNT_ONE >= st_ff.interval);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_data = s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      // Accumulate; sample in the task cycle goes into the snapshot
      nxt_st.motion_total = motion_sum;
      nxt_st.double_total = double_sum;
      if (task_both || task_motion) begin
         nxt_st.motion_snap = motion_sum;
         nxt_st.motion_total = REG_RESET;
      end
      if (task_both || task_double) begin
         nxt_st.double_snap = double_sum;
         nxt_st.double_total = REG_RESET;
      end
      // Interval counting
      if (sample_in.valid) begin
         nxt_st.count = interval_done ? 16'h0000 : st_ff.count + COUNT_ONE;
      end
      // Register writes; a software clear loses to a same-cycle set below
      if (wr_fire) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         if (hit(st_ff.aw_addr, OFF_EVT_SAMPLE)) begin
            nxt_st.new_sample_event = st_ff.w_data[0];
         end else if (hit(st_ff.aw_addr, OFF_EVT_REPORT)) begin
            nxt_st.report_nonzero_event = st_ff.w_data[0];
         end else if (hit(st_ff.aw_addr, OFF_REPORT_INTERVAL)) begin
            nxt_st.interval = st_ff.w_data[15:0];
            nxt_st.count = 16'h0000;
         end else if (!(task_both || task_motion || task_double
               || hit(st_ff.aw_addr, OFF_TASK_BOTH) || hit(st_ff.aw_addr, OFF_TASK_MOTION)
               || hit(st_ff.aw_addr, OFF_TASK_DOUBLE))) begin
            nxt_st.bresp = RESP_SLVERR;
         end
      end
      // Event sets win over clears
      if (sample_in.valid) begin
         nxt_st.new_sample_event = 1'b1;
      end
      if (interval_done && motion_sum != REG_RESET) begin
         nxt_st.report_nonzero_event = 1'b1;
      end
      nxt_st.double_seen_event = interval_done && double_sum != REG_RESET;
      // Read path
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         nxt_st.rdata = REG_RESET;
         if (hit(s_axi_araddr, OFF_EVT_SAMPLE)) begin
            nxt_st.rdata = {31'h0000_0000, st_ff.new_sample_event};
         end else if (hit(s_axi_araddr, OFF_EVT_REPORT)) begin
            nxt_st.rdata = {31'h0000_0000, st_ff.report_nonzero_event};
         end else if (hit(s_axi_araddr, OFF_REPORT_INTERVAL)) begin
            nxt_st.rdata = {16'h0000, st_ff.interval};
         end else if (hit(s_axi_araddr, OFF_MOTION_TOTAL)) begin
            nxt_st.rdata = st_ff.motion_total;
         end else if (hit(s_axi_araddr, OFF_MOTION_SNAP)) begin
            nxt_st.rdata = st_ff.motion_snap;
         end else if (hit(s_axi_araddr, OFF_DOUBLE_TOTAL)) begin
            nxt_st.rdata = st_ff.double_total;
         end else if (hit(s_axi_araddr, OFF_DOUBLE_SNAP)) begin
            nxt_st.rdata = st_ff.double_snap;
         end else if (!(hit(s_axi_araddr, OFF_TASK_BOTH) || hit(s_axi_araddr, OFF_TASK_MOTION)
               || hit(s_axi_araddr, OFF_TASK_DOUBLE))) begin
            nxt_st.rresp = RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.interval <= INTERVAL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_BOTH_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      task_both |=> st_ff.motion_total == 32'h0000_0000 && st_ff.double_total == 32'h0000_0000
      && st_ff.motion_snap == $past(motion_sum) && st_ff.double_snap == $past(double_sum))
      else $error("both snapshot wrong");
   AST_MOTION_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      task_motion && !task_both |=> st_ff.motion_total == 32'h0000_0000
      && st_ff.motion_snap == $past(motion_sum))
      else $error("motion snapshot wrong");
   AST_DOUBLE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      task_double && !task_both |=> st_ff.double_total == 32'h0000_0000
      && st_ff.double_snap == $past(double_sum) && $stable(st_ff.motion_snap))
      else $error("double snapshot wrong");
   AST_SAMPLE_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_in.valid |=> st_ff.new_sample_event)
      else $error("sample event missed");
   AST_REPORT_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(st_ff.report_nonzero_event)
      |-> ($past(interval_done) && $past(motion_sum) != 32'h0000_0000) || $past(report_sw_set))
      else $error("report event without cause");
   AST_DOUBLE_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
      st_ff.double_seen_event |-> $past(interval_done) && $past(double_sum) != 32'h0000_0000)
      else $error("double event without cause");
   AST_EVT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && hit(st_ff.aw_addr, OFF_EVT_SAMPLE) && !st_ff.w_data[0] && !sample_in.valid
      |=> !st_ff.new_sample_event)
      else $error("event clear failed");
   AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid ##0 !s_axi_awready)
      else $error("write response missing");
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 Self-checking bench for the quadrature decoder snapshot and event block.
 Assumes qdsn_pkg and qdsn_top are compiled first; drives AXI4-Lite and the
 sample stream directly, no partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
   import qdsn_pkg::*;
;
   logic aclk, aresetn, bvalid, rvalid, awready, wready, arready, dbl_pulse;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   qdsn_sample_t sample_in;
   int fails = 0;
   int compares = 0;

   qdsn_top u_dut (.aclk(aclk), .aresetn(aresetn), .sample_in(sample_in), .double_seen_event(dbl_pulse),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Single compare for every 32-bit result
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
         if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "write response");
   endtask

   // Read and compare data and response code
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] rsp = RESP_OKAY);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, exp, "read data");
      chk({30'h0, rresp}, {30'h0, rsp}, "read response");
   endtask

   // One-cycle sample pulse; returns the double pulse seen one edge later
   task automatic sample(input logic [31:0] m, input logic [3:0] d, output logic p);
      @(posedge aclk);
      sample_in <= '{valid: 1'b1, motion: m, doubles: d};
      @(posedge aclk);
      sample_in.valid <= 1'b0;
      // The pulse is registered at the sampling edge, so look one edge on
      @(posedge aclk);
      p = dbl_pulse;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd_chk(OFF_EVT_SAMPLE, 32'h0000_0000);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      rd_chk(OFF_REPORT_INTERVAL, {16'h0000, INTERVAL_RESET});
      rd_chk(OFF_TASK_BOTH, 32'h0000_0000);
      rd_chk(12'h200, 32'h0000_0000, RESP_SLVERR);
      $display("test reset done");
   endtask

   // Interval of three: report only on the third sample, event cleared by 0
   task automatic t_events();
      logic p;
      wr(OFF_REPORT_INTERVAL, 32'h0000_0003);
      sample(32'h0000_0005, 4'h1, p);
      chk({31'h0, p}, 32'h0000_0000, "double pulse early");
      rd_chk(OFF_EVT_SAMPLE, 32'h0000_0001);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      sample(32'h0000_0005, 4'h0, p);
      sample(32'h0000_0005, 4'h2, p);
      chk({31'h0, p}, 32'h0000_0001, "double pulse at interval");
      rd_chk(OFF_EVT_REPORT, 32'h0000_0001);
      wr(OFF_EVT_SAMPLE, 32'h0000_0000);
      wr(OFF_EVT_REPORT, 32'h0000_0000);
      rd_chk(OFF_EVT_SAMPLE, 32'h0000_0000);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      // Writing 1 sets the event by choice; clear it again for later tests
      wr(OFF_EVT_REPORT, 32'h0000_0001);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0001);
      wr(OFF_EVT_REPORT, 32'h0000_0000);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      $display("test events done");
   endtask

   // Each snapshot task touches only its own totals
   task automatic t_tasks();
      logic p;
      wr(OFF_TASK_MOTION, 32'h0000_0001);
      rd_chk(OFF_MOTION_SNAP, 32'h0000_000f);
      rd_chk(OFF_MOTION_TOTAL, 32'h0000_0000);
      rd_chk(OFF_DOUBLE_TOTAL, 32'h0000_0003);
      wr(OFF_TASK_DOUBLE, 32'h0000_0001);
      rd_chk(OFF_DOUBLE_SNAP, 32'h0000_0003);
      rd_chk(OFF_DOUBLE_TOTAL, 32'h0000_0000);
      rd_chk(OFF_MOTION_SNAP, 32'h0000_000f);
      sample(32'h0000_0007, 4'h2, p);
      wr(OFF_TASK_BOTH, 32'h0000_0001);
      rd_chk(OFF_MOTION_SNAP, 32'h0000_0007);
      rd_chk(OFF_DOUBLE_SNAP, 32'h0000_0002);
      rd_chk(OFF_MOTION_TOTAL, 32'h0000_0000);
      rd_chk(OFF_DOUBLE_TOTAL, 32'h0000_0000);
      // Sample landing in the task's execute cycle must end up in the snapshot
      fork
         wr(OFF_TASK_MOTION, 32'h0000_0001);
         begin
            @(posedge aclk);
            sample(32'h0000_0006, 4'h0, p);
         end
      join
      rd_chk(OFF_MOTION_SNAP, 32'h0000_0006);
      rd_chk(OFF_MOTION_TOTAL, 32'h0000_0000);
      $display("test tasks done");
   endtask

   // Motion that cancels out must not report; a later nonzero total must
   task automatic t_zero();
      logic p;
      wr(OFF_REPORT_INTERVAL, 32'h0000_0002);
      sample(32'h0000_0004, 4'h0, p);
      sample(32'hffff_fffc, 4'h0, p);
      chk({31'h0, p}, 32'h0000_0000, "double pulse with zero total");
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      sample(32'h0000_0009, 4'h0, p);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0000);
      sample(32'h0000_0000, 4'h0, p);
      rd_chk(OFF_EVT_REPORT, 32'h0000_0001);
      $display("test zero done");
   endtask

   // ----------------------------------------
   // Clock, reset, sequence and verdict
   // ----------------------------------------
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      final_report();
   end

   initial begin
      aresetn = 1'b0; sample_in = '0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_events();
      t_tasks();
      t_zero();
      final_report();
   end
endmodule
`default_nettype wire
